// ==== ppt_pkg.sv ====
package ppt_pkg;

	// ************************************************************
	// register map (byte addresses on apb)
	// ************************************************************
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_TIMING  = 8'h04;
	localparam logic [7:0] OFF_EVENT   = 8'h08;
	localparam logic [7:0] OFF_MASK    = 8'h0c;
	localparam logic [7:0] OFF_RXDATA  = 8'h10;
	localparam logic [7:0] OFF_STATUS  = 8'h14;
	localparam logic [7:0] OFF_TXDATA  = 8'h18;
	localparam logic [7:0] OFF_CTLCHAR = 8'h1c;

	// ************************************************************
	// field layout
	// ************************************************************
	localparam int CTRL_DIR_BIT    = 0;
	localparam int CTRL_MODE_LSB   = 1;
	localparam int CTRL_REJECT_BIT = 3;
	localparam int TIM_FIRST_LSB   = 0;
	localparam int TIM_SECOND_LSB  = 8;
	localparam int EV_RX_BIT       = 0;
	localparam int EV_TX_BIT       = 1;
	localparam int EV_CCR_BIT      = 2;
	localparam logic [7:0] EV_IMPL_MASK = 8'h0f;
	localparam int ST_BUSY_BIT     = 0;
	localparam int ST_TXPEND_BIT   = 1;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [3:0]  CTRL_RST   = 4'h0;
	localparam logic [15:0] TIMING_RST = 16'h0000;
	localparam logic [7:0]  EVENT_RST  = 8'h00;
	localparam logic [7:0]  MASK_RST   = 8'h00;
	localparam logic [7:0]  BYTE_RST   = 8'h00;

	// ************************************************************
	// timing: system clock period and the short fixed phase
	// ************************************************************
	localparam int PCLK_PERIOD_NS = 100;
	localparam logic [7:0] NONPULSED_COUNT = 8'h00;

	typedef enum logic [1:0] {
		PPT_MODE_OFF     = 2'b00,
		PPT_MODE_INTERLK = 2'b01,
		PPT_MODE_PULSED  = 2'b10,
		PPT_MODE_TRANSP  = 2'b11
	} ppt_mode_e;

	typedef enum logic [1:0] {
		PPT_ST_IDLE  = 2'b00,
		PPT_ST_SETUP = 2'b01,
		PPT_ST_PULSE = 2'b10
	} ppt_state_e;

endpackage

// ==== ppt_timer.sv ====
`timescale 1ns/1ps
module ppt_timer
	import ppt_pkg::*;
#(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// control
	input  wire logic         start,
	input  wire logic [W-1:0] count,
	// status
	output logic              busy,
	output logic              done
);

	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic         busy_ff;
	logic         nxt_busy;

	// value n stays busy for n+1 cycles, done in the last
	assign done = busy_ff && (cnt_ff == '0);
	assign busy = busy_ff;

	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_busy = busy_ff;
		if (start) begin
			nxt_cnt  = count;
			nxt_busy = 1'b1;
		end else if (done) begin
			nxt_busy = 1'b0;
		end else if (busy_ff) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff  <= '0;
			busy_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			busy_ff <= nxt_busy;
		end
	end

endmodule

// ==== ppt_top.sv ====
// Operation
// - direction bit 0 receives, 1 transmits
// - 16-bit timing register, second high, first low
// - first timing value n gives n+1 clocks (code: pulsed mode only; other modes give 1 clock)
// - second timing value n gives n+1 clocks (code: pulsed mode only; other modes give 1 clock)
// - both timings apply to transmit and receive
// - recognised events set bits in event register
// - event register shares serial channel address
// - write one clears event bit, zero keeps
// - event register reads without side effect
// - interrupt holds until unmasked events cleared
// - mask blocks interrupt, event still recorded
// - rejected control character stored, flag set
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module ppt_top
	import ppt_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// parallel port pins
	input  wire logic [7:0]  pdata_in,
	output logic [7:0]       pdata_out,
	output logic             pdata_oe,
	input  wire logic        hs_in,
	input  wire logic        ctrl_flag_in,
	output logic             hs_out,
	// interrupt
	output logic             irq
);

	// ************************************************************
	// state
	// ************************************************************
	logic [3:0]  ctrl_ff,    nxt_ctrl;
	logic [15:0] timing_ff,  nxt_timing;
	logic [7:0]  event_ff,   nxt_event;
	logic [7:0]  mask_ff,    nxt_mask;
	logic [7:0]  rxdata_ff,  nxt_rxdata;
	logic [7:0]  txbuf_ff,   nxt_txbuf;
	logic [7:0]  ctlchar_ff, nxt_ctlchar;
	logic [7:0]  dout_ff,    nxt_dout;
	logic [7:0]  lat_t2_ff,  nxt_lat_t2;
	logic [31:0] prdata_ff,  nxt_prdata;
	logic        txpend_ff,  nxt_txpend;
	logic        hs_out_ff,  nxt_hs_out;
	logic        hs_in_d_ff;
	ppt_state_e  state_ff,   nxt_state;

	logic        wr_en;
	logic        rd_setup;
	logic        mapped;
	logic [7:0]  ev_set;
	logic [7:0]  ev_clr;
	logic        tmr_start;
	logic [7:0]  tmr_count;
	logic        tmr_done;
	logic        dir_tx;
	logic        active;
	logic        pulsed;
	logic [7:0]  t1;
	logic [7:0]  t2;
	ppt_mode_e   mode;

	assign dir_tx = ctrl_ff[CTRL_DIR_BIT];
	assign mode   = ppt_mode_e'(ctrl_ff[CTRL_MODE_LSB +: 2]);
	assign active = (mode != PPT_MODE_OFF);
	assign pulsed = (mode == PPT_MODE_PULSED);
	// other handshake modes run the phases at the shortest length
	assign t1 = pulsed ? timing_ff[TIM_FIRST_LSB +: 8] : NONPULSED_COUNT;
	assign t2 = pulsed ? timing_ff[TIM_SECOND_LSB +: 8] : NONPULSED_COUNT;

	// ************************************************************
	// apb slave: zero wait states, read data latched in setup
	// ************************************************************
	assign wr_en    = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready   = 1'b1;
	assign prdata   = prdata_ff;
	assign pslverr  = psel && penable && !mapped;

	always_comb begin
		case (paddr)
			OFF_CTRL, OFF_TIMING, OFF_EVENT, OFF_MASK,
			OFF_RXDATA, OFF_STATUS, OFF_TXDATA, OFF_CTLCHAR: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		nxt_prdata = prdata_ff;
		if (rd_setup) begin
			case (paddr)
				OFF_CTRL:    nxt_prdata = {28'h0000000, ctrl_ff};
				OFF_TIMING:  nxt_prdata = {16'h0000, timing_ff};
				// shares the serial channel's event address; no side effect
				OFF_EVENT:   nxt_prdata = {24'h000000, event_ff};
				OFF_MASK:    nxt_prdata = {24'h000000, mask_ff};
				OFF_RXDATA:  nxt_prdata = {24'h000000, rxdata_ff};
				OFF_STATUS:  nxt_prdata = {30'h00000000, txpend_ff,
					state_ff != PPT_ST_IDLE};
				OFF_TXDATA:  nxt_prdata = {24'h000000, txbuf_ff};
				OFF_CTLCHAR: nxt_prdata = {24'h000000, ctlchar_ff};
				default:     nxt_prdata = 32'h00000000;
			endcase
		end
	end

	// ************************************************************
	// configuration registers
	// ************************************************************
	always_comb begin
		nxt_ctrl   = ctrl_ff;
		nxt_timing = timing_ff;
		nxt_mask   = mask_ff;
		nxt_txbuf  = txbuf_ff;
		if (wr_en) begin
			case (paddr)
				OFF_CTRL:   nxt_ctrl   = pwdata[3:0];
				OFF_TIMING: nxt_timing = pwdata[15:0];
				OFF_MASK:   nxt_mask   = pwdata[7:0] & EV_IMPL_MASK;
				OFF_TXDATA: nxt_txbuf  = pwdata[7:0];
				default:    nxt_ctrl   = ctrl_ff;
			endcase
		end
	end

	// ************************************************************
	// events and interrupt
	// ************************************************************
	assign ev_clr = (wr_en && paddr == OFF_EVENT) ? pwdata[7:0] : 8'h00;

	always_comb begin
		// a set in the clearing cycle wins
		nxt_event = ((event_ff & ~ev_clr) | ev_set) & EV_IMPL_MASK;
	end

	assign irq = |(event_ff & mask_ff);

	// ************************************************************
	// handshake sequencer
	// ************************************************************
	ppt_timer #(
		.W(8)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (tmr_start),
		.count   (tmr_count),
		.busy    (),
		.done    (tmr_done)
	);

	always_comb begin
		nxt_state   = state_ff;
		nxt_rxdata  = rxdata_ff;
		nxt_ctlchar = ctlchar_ff;
		nxt_dout    = dout_ff;
		nxt_lat_t2  = lat_t2_ff;
		nxt_hs_out  = hs_out_ff;
		nxt_txpend  = txpend_ff;
		ev_set      = 8'h00;
		tmr_start   = 1'b0;
		tmr_count   = t1;
		if (wr_en && paddr == OFF_TXDATA) begin
			nxt_txpend = 1'b1;
		end
		case (state_ff)
			PPT_ST_IDLE: begin
				if (active && dir_tx && txpend_ff) begin
					nxt_dout   = txbuf_ff;
					nxt_txpend = 1'b0;
					nxt_lat_t2 = t2;
					tmr_start  = 1'b1;
					nxt_state  = PPT_ST_SETUP;
				end else if (active && !dir_tx && hs_in && !hs_in_d_ff) begin
					if (ctrl_flag_in && ctrl_ff[CTRL_REJECT_BIT]) begin
						nxt_ctlchar         = pdata_in;
						ev_set[EV_CCR_BIT]  = 1'b1;
					end else begin
						nxt_rxdata          = pdata_in;
						ev_set[EV_RX_BIT]   = 1'b1;
					end
					nxt_lat_t2 = t2;
					tmr_start  = 1'b1;
					nxt_state  = PPT_ST_SETUP;
				end
			end
			PPT_ST_SETUP: begin
				if (tmr_done) begin
					tmr_start  = 1'b1;
					tmr_count  = lat_t2_ff;
					nxt_hs_out = 1'b1;
					nxt_state  = PPT_ST_PULSE;
				end
			end
			PPT_ST_PULSE: begin
				if (tmr_done) begin
					nxt_hs_out = 1'b0;
					nxt_state  = PPT_ST_IDLE;
					if (dir_tx) begin
						ev_set[EV_TX_BIT] = 1'b1;
					end
				end
			end
			default: begin
				nxt_hs_out = 1'b0;
				nxt_state  = PPT_ST_IDLE;
			end
		endcase
	end

	// drive the bus only as a transmitter
	assign pdata_oe  = active && dir_tx;
	assign pdata_out = dout_ff;
	assign hs_out    = hs_out_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff    <= CTRL_RST;
			timing_ff  <= TIMING_RST;
			event_ff   <= EVENT_RST;
			mask_ff    <= MASK_RST;
			rxdata_ff  <= BYTE_RST;
			txbuf_ff   <= BYTE_RST;
			ctlchar_ff <= BYTE_RST;
			dout_ff    <= BYTE_RST;
			lat_t2_ff  <= BYTE_RST;
			prdata_ff  <= 32'h00000000;
			txpend_ff  <= 1'b0;
			hs_out_ff  <= 1'b0;
			hs_in_d_ff <= 1'b0;
			state_ff   <= PPT_ST_IDLE;
		end else begin
			ctrl_ff    <= nxt_ctrl;
			timing_ff  <= nxt_timing;
			event_ff   <= nxt_event;
			mask_ff    <= nxt_mask;
			rxdata_ff  <= nxt_rxdata;
			txbuf_ff   <= nxt_txbuf;
			ctlchar_ff <= nxt_ctlchar;
			dout_ff    <= nxt_dout;
			lat_t2_ff  <= nxt_lat_t2;
			prdata_ff  <= nxt_prdata;
			txpend_ff  <= nxt_txpend;
			hs_out_ff  <= nxt_hs_out;
			hs_in_d_ff <= hs_in;
			state_ff   <= nxt_state;
		end
	end

	// ************************************************************
	// checks; helper counts cycles spent in the current phase
	// ************************************************************
	logic [8:0] ph_cnt_ff;
	logic [7:0] lat_t1_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_cnt_ff <= 9'h000;
			lat_t1_ff <= 8'h00;
		end else begin
			ph_cnt_ff <= (nxt_state != state_ff) ? 9'h001 : ph_cnt_ff + 9'h001;
			if (tmr_start && state_ff == PPT_ST_IDLE) begin
				lat_t1_ff <= t1;
			end
		end
	end

	dir_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
		pdata_oe |-> (ctrl_ff[CTRL_DIR_BIT] && mode != PPT_MODE_OFF))
		else $error("data driven while not a transmitter");
	timing_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == OFF_TIMING) |=> timing_ff == $past(pwdata[15:0]))
		else $error("timing register did not take the write");
	setup_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == PPT_ST_SETUP && nxt_state == PPT_ST_PULSE)
		|-> ph_cnt_ff == {1'b0, lat_t1_ff} + 9'h001)
		else $error("first phase length wrong");
	pulse_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(hs_out) |-> $past(ph_cnt_ff) == {1'b0, lat_t2_ff} + 9'h001)
		else $error("second phase length wrong");
	rx_event_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ev_set[EV_RX_BIT]) |=> event_ff[EV_RX_BIT] && rxdata_ff == $past(pdata_in))
		else $error("receive event not recorded");
	// a zero written to the receive bit must leave it alone
	w1c_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ev_clr[EV_TX_BIT] && !ev_set[EV_TX_BIT]) ##1 !ev_set[EV_TX_BIT]
		|-> !event_ff[EV_TX_BIT] && (!$past(event_ff[EV_RX_BIT])
		|| event_ff[EV_RX_BIT] || $past(ev_clr[EV_RX_BIT])))
		else $error("write one did not clear event bit");
	read_clean_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_setup && paddr == OFF_EVENT && ev_clr == 8'h00)
		|=> (($past(event_ff) & ~event_ff) == 8'h00))
		else $error("event read changed a bit");
	// irq may only drop after an unmasked set bit is cleared
	irq_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(($past(irq) && mask_ff == $past(mask_ff)
		&& $past(ev_clr & event_ff & mask_ff) == 8'h00) |-> irq)
		and ((mask_ff == 8'h00) |-> !irq))
		else $error("interrupt level does not follow unmasked events");
	ccr_store_a: assert property (@(posedge pclk) disable iff (!presetn)
		ev_set[EV_CCR_BIT] |=> event_ff[EV_CCR_BIT] && ctlchar_ff == $past(pdata_in))
		else $error("control character not stored");
	resv_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		event_ff[7:4] == 4'h0 && mask_ff[7:4] == 4'h0)
		else $error("reserved event bits not zero");

endmodule

// ==== ppt_peer.sv ====
`timescale 1ns/1ps
module ppt_peer (
	// clock
	input  wire logic       pclk,
	// port pins as seen by the peer
	input  wire logic       hs_out,
	input  wire logic [7:0] pdata_out,
	input  wire logic       pdata_oe,
	output logic [7:0]      pdata_in,
	output logic            hs_in,
	output logic            ctrl_flag_in
);
	logic [7:0] got;
	int         hi;

	initial begin
		pdata_in = 8'h00;
		hs_in = 1'b0;
		ctrl_flag_in = 1'b0;
		got = 8'h00;
	end

	// latch the byte while the strobe is up
	always @(posedge pclk) begin
		if (hs_out && pdata_oe)
			got <= pdata_out;
	end

	// data inverted after release so a stale bus never looks valid
	task automatic send(input logic [7:0] d, input logic f, input int wt);
		int k;
		repeat (wt) @(posedge pclk);
		pdata_in <= d;
		ctrl_flag_in <= f;
		hs_in <= 1'b1;
		k = 0;
		while (hs_out !== 1'b1 && k < 600) begin
			@(posedge pclk);
			k++;
		end
		hi = 0;
		while (hs_out === 1'b1 && hi < 600) begin
			@(posedge pclk);
			hi++;
		end
		hs_in <= 1'b0;
		pdata_in <= ~d;
		ctrl_flag_in <= ~f;
	endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb
	import ppt_pkg::*;
;
	// ****************
	// bench state
	// ****************
	localparam logic [7:0] REGS [7] = '{OFF_CTRL, OFF_TIMING, OFF_EVENT,
		OFF_MASK, OFF_RXDATA, OFF_STATUS, OFF_CTLCHAR};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        pdata_oe, hs_in, ctrl_flag_in, hs_out, irq, err;
	logic [7:0]  paddr, pdata_in, pdata_out, b;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] tim;
	int          fail_count, checks, cyc;

	ppt_top ppt_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pdata_in(pdata_in), .pdata_out(pdata_out), .pdata_oe(pdata_oe),
		.hs_in(hs_in), .ctrl_flag_in(ctrl_flag_in), .hs_out(hs_out),
		.irq(irq));
	ppt_peer ppt_peer_inst (.pclk(pclk), .hs_out(hs_out),
		.pdata_out(pdata_out), .pdata_oe(pdata_oe), .pdata_in(pdata_in),
		.hs_in(hs_in), .ctrl_flag_in(ctrl_flag_in));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic close_out();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// longest walk is a little under twenty-three hundred cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			close_out();
		end
	end

	// ****************
	// tasks
	// ****************
	function automatic logic [31:0] clocks(input logic [1:0] m,
		input logic [7:0] v);
		return (m == PPT_MODE_PULSED) ? 32'(v) + 1 : 32'h1;
	endfunction

	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask

	// one idle edge after each transfer keeps drives one per time step
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rchk(input string s, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, e, rd);
	endtask

	task automatic tx(input logic [1:0] m, input logic [15:0] t);
		int k;
		apb(1'b1, OFF_TIMING, {16'h0, t});
		apb(1'b1, OFF_CTRL, {29'h0, m, 1'b1});
		chk("tx enable", 32'h1, {31'h0, pdata_oe});
		b = 8'($urandom);
		apb(1'b1, OFF_TXDATA, {24'h0, b});
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (hs_out !== 1'b1 && k < 600);
		// the loop sees hs_out one edge after it rises
		chk("strobe delay", clocks(m, t[7:0]) + 32'h1, 32'(k));
		k = 0;
		while (hs_out === 1'b1 && k < 600) begin
			@(posedge pclk);
			k++;
		end
		chk("strobe width", clocks(m, t[15:8]), 32'(k));
		chk("tx byte", {24'h0, b}, {24'h0, ppt_peer_inst.got});
		rchk("tx event", OFF_EVENT, 32'h2);
		apb(1'b1, OFF_EVENT, 32'h2);
	endtask

	task automatic rx(input logic [7:0] d, input logic f, input logic rj,
		input logic [15:0] t);
		apb(1'b1, OFF_EVENT, 32'hff);
		apb(1'b1, OFF_TIMING, {16'h0, t});
		apb(1'b1, OFF_CTRL, {28'h0, rj, PPT_MODE_PULSED, 1'b0});
		chk("rx enable", 32'h0, {31'h0, pdata_oe});
		ppt_peer_inst.send(d, f, $urandom_range(0, 3));
		chk("ack width", 32'(t[15:8]) + 1, 32'(ppt_peer_inst.hi));
		if (f && rj) begin
			rchk("ctl char", OFF_CTLCHAR, {24'h0, d});
			rchk("ctl event", OFF_EVENT, 32'h4);
		end else begin
			rchk("rx byte", OFF_RXDATA, {24'h0, d});
			rchk("rx event", OFF_EVENT, 32'h1);
		end
	endtask

	// ****************
	// sequence
	// ****************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		void'($urandom(63764));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (REGS[i]) rchk("reset value", REGS[i], 32'h0);
		rchk("unmapped read", 8'h40, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("ready", 32'h1, {31'h0, pready});
		tim = 16'($urandom);
		apb(1'b1, OFF_TIMING, {16'hffff, tim});
		rchk("timing", OFF_TIMING, {16'h0, tim});
		apb(1'b1, OFF_CTRL, 32'h1);
		chk("off enable", 32'h0, {31'h0, pdata_oe});
		for (int m = 1; m < 4; m++)
			tx(2'(m), 16'($urandom_range(0, 16'h2828)));
		tx(PPT_MODE_PULSED, 16'h00ff);
		tx(PPT_MODE_PULSED, 16'hff00);
		rx(8'h5a, 1'b0, 1'b0, 16'h0300);
		chk("irq masked", 32'h0, {31'h0, irq});
		rchk("event kept", OFF_EVENT, 32'h1);
		apb(1'b1, OFF_MASK, 32'h1);
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(1'b1, OFF_EVENT, 32'hfe);
		rchk("event w0", OFF_EVENT, 32'h1);
		chk("irq held", 32'h1, {31'h0, irq});
		apb(1'b1, OFF_EVENT, 32'hff);
		chk("irq clear", 32'h0, {31'h0, irq});
		rx(8'ha5, 1'b1, 1'b1, 16'h0000);
		chk("irq other", 32'h0, {31'h0, irq});
		rx(8'h3c, 1'b1, 1'b0, 16'h0102);
		repeat (4)
			rx(8'($urandom), 1'($urandom), 1'($urandom),
				16'($urandom_range(0, 16'h2020)));
		close_out();
	end
endmodule
